//--- fb_pkg.sv
// Purpose: Shared constants and types for the fan board command group.
// Assumes: 50 MHz aclk, AXI4-Lite register access, up to 32 boards.
// Notes: Constants and types only, grouped below as protocol, timing, register map and types.
package fb_pkg;
  // ==========================================================
  // Protocol
  localparam int NB = 32;
  localparam int NF = 4;
  localparam logic [7:0] REQ_TYPE = 8'h25;
  localparam logic [7:0] REP_TYPE = 8'h65;
  localparam logic [7:0] ERR_TYPE = 8'he5;
  localparam logic [7:0] SUB_INFO = 8'h00;
  localparam logic [7:0] SUB_FAN = 8'h01;
  localparam logic [7:0] SUB_TACH = 8'h02;
  localparam logic [7:0] LVL_MAX = 8'h64;
  localparam logic [6:0] GLITCH_RST = 7'h01;
  localparam logic [7:0] LEN_INFO = 8'h02;
  localparam logic [7:0] LEN_SN = 8'h12;
  localparam logic [7:0] LEN_FAN_RD = 8'h0c;
  localparam logic [7:0] LEN_TACH = 8'h0e;
  localparam logic [3:0] SN_LAST = 4'hf;
  localparam logic [6:0] STEPS = 7'h64;
  // ==========================================================
  // Timing
  localparam real CLK_MHZ = 50.0;
  localparam real STEP_US = 552.5;
  localparam int STEP_CYC_DEF = int'(STEP_US * CLK_MHZ);
  localparam real EIGHTH_S = 0.125;
  localparam int EIGHTH_CYC_DEF = int'(EIGHTH_S * CLK_MHZ * 1.0e6);
  localparam int TACH_S = 60;
  localparam logic [8:0] TACH_EIGHTHS = 9'(TACH_S * 8);
  // ==========================================================
  // Register map
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_REQ0 = 8'h10;
  localparam int REQ_BYTES = 12;
  localparam logic [7:0] A_REP0 = 8'h20;
  localparam int REP_BYTES = 20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_EXEC = 3'h2,
    S_SN = 3'h4
  } ctl_e;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;
  typedef struct packed {
    logic [NF-1:0] pwm;
    logic [NF-1:0][6:0] blank;
    logic [NF-1:0] tprev;
    logic [NF-1:0][7:0] cyc;
    logic [NF-1:0][15:0] tick;
  } board_state_s;
  typedef struct packed {
    ctl_e st;
    axil_rsp_s rsp;
    logic aw_ok;
    logic [7:0] awaddr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic done;
    logic err;
    logic [7:0] cmd_type;
    logic [7:0] cmd_len;
    logic [REQ_BYTES-1:0][7:0] req;
    logic [REP_BYTES-1:0][7:0] rep;
    logic [7:0] rep_type;
    logic [7:0] rep_len;
    logic [3:0] sn_k;
    logic [8:0] sn_addr;
    logic [NB-1:0][NF-1:0][6:0] pwr;
    logic [NB-1:0][NF-1:0] mask;
    logic [NB-1:0][7:0] tmo;
    logic [NB-1:0][NF-1:0][6:0] glitch;
    logic [NB-1:0][7:0] fs_cnt;
    logic [NB-1:0] fs_trip;
    logic [NB-1:0] tach_en;
    logic [NB-1:0][8:0] tach_cnt;
    logic [NB-1:0] tach_clr;
    logic [15:0] step_cnt;
    logic [22:0] eighth_cnt;
    logic [6:0] phase;
    logic step_tick;
    logic eighth_tick;
  } ctl_state_s;
endpackage

//--- fan_board.sv
// Purpose: PWM drive and tachometer capture for the four fans of one board.
// Assumes: phase and step_tick come from the shared 100-step time base.
// Notes: Counters saturate; a clear pulse restarts a measurement.
`timescale 1ns/1ps
module fan_board (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Time base
  input wire logic step_tick,
  input wire logic [6:0] phase,
  // Settings
  input wire logic [fb_pkg::NF-1:0][6:0] pwr,
  input wire logic [fb_pkg::NF-1:0][6:0] glitch,
  input wire logic [fb_pkg::NF-1:0] full_on,
  input wire logic tach_en,
  input wire logic tach_clr,
  // Fan pins
  input wire logic [fb_pkg::NF-1:0] tach_in,
  output logic [fb_pkg::NF-1:0] pwm,
  // Measurements
  output logic [fb_pkg::NF-1:0][7:0] cyc,
  output logic [fb_pkg::NF-1:0][15:0] tick
);
  fb_pkg::board_state_s s_r;
  fb_pkg::board_state_s s_nxt;

  // ==========================================================
  // Next state per fan
  always_comb begin
    logic on;
    on = 1'b0;
    s_nxt = s_r;
    for (int f = 0; f < fb_pkg::NF; f++) begin
      on = full_on[f] || (phase < pwr[f]);
      s_nxt.pwm[f] = on;
      // Blanking restarts at each turn-on edge
      if (on && !s_r.pwm[f]) begin
        s_nxt.blank[f] = glitch[f];
      end else if (step_tick && s_r.blank[f] != 7'h00) begin
        s_nxt.blank[f] = 7'(s_r.blank[f] - 7'h01);
      end
      s_nxt.tprev[f] = tach_in[f];
      if (tach_clr) begin
        s_nxt.cyc[f] = 8'h00;
        s_nxt.tick[f] = 16'h0000;
      end else if (tach_en) begin
        // Unpowered or blanked fans give false edges
        if (tach_in[f] && !s_r.tprev[f] && s_r.pwm[f] && s_r.blank[f] == 7'h00
            && s_r.cyc[f] != 8'hff) begin
          s_nxt.cyc[f] = 8'(s_r.cyc[f] + 8'h01);
        end
        if (step_tick && s_r.cyc[f] != 8'h00 && s_r.tick[f] != 16'hffff) begin
          s_nxt.tick[f] = 16'(s_r.tick[f] + 16'h0001);
        end
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pwm = s_r.pwm;
  assign cyc = s_r.cyc;
  assign tick = s_r.tick;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  for (genvar f = 0; f < fb_pkg::NF; f++) begin : g_chk
    a_full_drive: assert property (full_on[f] |=> pwm[f])
      else $error("forced fan not driven");
    a_zero_off: assert property (pwr[f] == 7'h00 && !full_on[f] |=> !pwm[f])
      else $error("zero power fan driven");
    a_blank_hold: assert property (s_r.blank[f] != 7'h00 && !tach_clr |=> cyc[f] == $past(cyc[f]))
      else $error("tach edge counted while blanked");
  end
endmodule // fan_board

//--- fan_board_command_group.sv
// Purpose: Command interpreter for the fan expansion board group.
// Assumes: Host packets are placed in registers; one command at a time.
// Notes: Serial numbers come from an external byte store via sn_addr.
`timescale 1ns/1ps
module fan_board_command_group #(
  parameter int STEP_CYC = fb_pkg::STEP_CYC_DEF,
  parameter int EIGHTH_CYC = fb_pkg::EIGHTH_CYC_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire fb_pkg::axil_req_s bus_req,
  output fb_pkg::axil_rsp_s bus_rsp,
  // Board chain
  input wire logic [5:0] board_count,
  output logic [8:0] sn_addr,
  input wire logic [7:0] sn_byte,
  // Fans, board b fan f at bit b*4+f
  input wire logic [fb_pkg::NB*fb_pkg::NF-1:0] tach_in,
  output logic [fb_pkg::NB*fb_pkg::NF-1:0] fan_pwm
);
  fb_pkg::ctl_state_s s_r;
  fb_pkg::ctl_state_s s_nxt;
  logic [fb_pkg::NB-1:0][fb_pkg::NF-1:0][7:0] cyc_w;
  logic [fb_pkg::NB-1:0][fb_pkg::NF-1:0][15:0] tick_w;

  // ==========================================================
  // Decoding helpers
  function automatic logic in_rng(input logic [7:0] a, input logic [7:0] base, input int n);
    return (a >= base) && (a < 8'(base + 8'(n)));
  endfunction

  // Index must name an attached board
  function automatic logic idx_ok(input logic [7:0] v, input logic [5:0] n);
    return (v < {2'h0, n}) && (v < 8'(fb_pkg::NB));
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic go;
    logic ok;
    logic [7:0] a;
    logic [7:0] sub;
    logic [7:0] len;
    logic [4:0] b;
    go = 1'b0;
    ok = 1'b0;
    a = 8'h00;
    sub = s_r.req[0];
    len = s_r.cmd_len;
    b = s_r.req[1][4:0];
    s_nxt = s_r;
    s_nxt.tach_clr = '0;

    // Step and eighth-second time bases
    s_nxt.step_tick = 1'b0;
    s_nxt.eighth_tick = 1'b0;
    if (s_r.step_cnt == 16'(STEP_CYC - 1)) begin
      s_nxt.step_cnt = 16'h0000;
      s_nxt.step_tick = 1'b1;
      s_nxt.phase = (s_r.phase == 7'(fb_pkg::STEPS - 7'h01)) ? 7'h00 : 7'(s_r.phase + 7'h01);
    end else begin
      s_nxt.step_cnt = 16'(s_r.step_cnt + 16'h0001);
    end
    if (s_r.eighth_cnt == 23'(EIGHTH_CYC - 1)) begin
      s_nxt.eighth_cnt = 23'h000000;
      s_nxt.eighth_tick = 1'b1;
    end else begin
      s_nxt.eighth_cnt = 23'(s_r.eighth_cnt + 23'h000001);
    end

    // Per-board watchdogs; a command later in this process overrides
    for (int i = 0; i < fb_pkg::NB; i++) begin
      if (s_r.eighth_tick && s_r.tmo[i] != 8'h00 && !s_r.fs_trip[i]) begin
        s_nxt.fs_cnt[i] = 8'(s_r.fs_cnt[i] + 8'h01);
        if (8'(s_r.fs_cnt[i] + 8'h01) == s_r.tmo[i]) begin
          s_nxt.fs_trip[i] = 1'b1;
        end
      end
      if (s_r.eighth_tick && s_r.tach_en[i]) begin
        if (s_r.tach_cnt[i] == 9'(fb_pkg::TACH_EIGHTHS - 9'h001)) begin
          s_nxt.tach_en[i] = 1'b0;
        end else begin
          s_nxt.tach_cnt[i] = 9'(s_r.tach_cnt[i] + 9'h001);
        end
      end
    end

    // Write channel: address and data taken in either order
    if (s_r.rsp.bvalid && bus_req.bready) begin
      s_nxt.rsp.bvalid = 1'b0;
    end
    if (bus_req.awvalid && s_r.rsp.awready) begin
      s_nxt.aw_ok = 1'b1;
      s_nxt.awaddr = bus_req.awaddr;
    end
    if (bus_req.wvalid && s_r.rsp.wready) begin
      s_nxt.w_ok = 1'b1;
      s_nxt.wdata = bus_req.wdata;
      s_nxt.wstrb = bus_req.wstrb;
    end
    if (s_r.aw_ok && s_r.w_ok) begin
      a = s_r.awaddr & 8'hfc;
      s_nxt.aw_ok = 1'b0;
      s_nxt.w_ok = 1'b0;
      s_nxt.rsp.bvalid = 1'b1;
      s_nxt.rsp.bresp = fb_pkg::RESP_OKAY;
      // Request registers are frozen while a command runs
      if (a == fb_pkg::A_CTRL) begin
        go = (s_r.st == fb_pkg::S_IDLE) && s_r.wstrb[0] && s_r.wdata[0];
      end else if (a == fb_pkg::A_CMD) begin
        if (s_r.st == fb_pkg::S_IDLE && s_r.wstrb[0]) begin
          s_nxt.cmd_type = s_r.wdata[7:0];
        end
        if (s_r.st == fb_pkg::S_IDLE && s_r.wstrb[1]) begin
          s_nxt.cmd_len = s_r.wdata[15:8];
        end
      end else if (in_rng(a, fb_pkg::A_REQ0, fb_pkg::REQ_BYTES)) begin
        for (int j = 0; j < 4; j++) begin
          if (s_r.st == fb_pkg::S_IDLE && s_r.wstrb[j]) begin
            s_nxt.req[4'(a - fb_pkg::A_REQ0) + 4'(j)] = s_r.wdata[8*j +: 8];
          end
        end
      end else if (a == fb_pkg::A_STAT || in_rng(a, fb_pkg::A_REP0, fb_pkg::REP_BYTES)) begin
        s_nxt.rsp.bresp = fb_pkg::RESP_OKAY; // Read-only, write ignored
      end else begin
        s_nxt.rsp.bresp = fb_pkg::RESP_SLVERR;
      end
    end
    s_nxt.rsp.awready = !s_nxt.aw_ok && !s_nxt.rsp.bvalid;
    s_nxt.rsp.wready = !s_nxt.w_ok && !s_nxt.rsp.bvalid;

    // Read channel: one outstanding read
    if (s_r.rsp.rvalid && bus_req.rready) begin
      s_nxt.rsp.rvalid = 1'b0;
    end
    if (bus_req.arvalid && s_r.rsp.arready) begin
      a = bus_req.araddr & 8'hfc;
      s_nxt.rsp.rvalid = 1'b1;
      s_nxt.rsp.rresp = fb_pkg::RESP_OKAY;
      s_nxt.rsp.rdata = 32'h00000000;
      if (a == fb_pkg::A_CTRL) begin
        s_nxt.rsp.rdata = 32'h00000000;
      end else if (a == fb_pkg::A_CMD) begin
        s_nxt.rsp.rdata = {16'h0000, s_r.cmd_len, s_r.cmd_type};
      end else if (a == fb_pkg::A_STAT) begin
        s_nxt.rsp.rdata = {8'h00, s_r.rep_len, s_r.rep_type, 5'h00, s_r.err, s_r.done,
                           s_r.st != fb_pkg::S_IDLE};
      end else if (in_rng(a, fb_pkg::A_REQ0, fb_pkg::REQ_BYTES)) begin
        s_nxt.rsp.rdata = s_r.req[4'(a - fb_pkg::A_REQ0) +: 4];
      end else if (in_rng(a, fb_pkg::A_REP0, fb_pkg::REP_BYTES)) begin
        s_nxt.rsp.rdata = s_r.rep[5'(a - fb_pkg::A_REP0) +: 4];
      end else begin
        s_nxt.rsp.rresp = fb_pkg::RESP_SLVERR;
      end
    end
    s_nxt.rsp.arready = !s_nxt.rsp.rvalid;

    // Command sequencing
    unique case (s_r.st)
      fb_pkg::S_IDLE: begin
        if (go) begin
          s_nxt.st = fb_pkg::S_EXEC;
          s_nxt.done = 1'b0;
        end
      end
      fb_pkg::S_EXEC: begin
        s_nxt.rep = '0;
        s_nxt.rep_len = 8'h00;
        s_nxt.rep[0] = sub;
        s_nxt.rep[1] = s_r.req[1];
        s_nxt.st = fb_pkg::S_IDLE;
        if (s_r.cmd_type == fb_pkg::REQ_TYPE) begin
          if (sub == fb_pkg::SUB_INFO && len == 8'h01) begin
            ok = 1'b1;
            s_nxt.rep[1] = {2'h0, board_count};
            s_nxt.rep_len = fb_pkg::LEN_INFO;
          end else if (sub == fb_pkg::SUB_INFO && len == 8'h02
                       && idx_ok(s_r.req[1], board_count)) begin
            ok = 1'b1;
            s_nxt.rep_len = fb_pkg::LEN_SN;
            s_nxt.st = fb_pkg::S_SN;
            s_nxt.sn_k = 4'h0;
            s_nxt.sn_addr = {b, 4'h0};
          end else if (sub == fb_pkg::SUB_FAN && len == 8'h02
                       && idx_ok(s_r.req[1], board_count)) begin
            ok = 1'b1;
            s_nxt.rep_len = fb_pkg::LEN_FAN_RD;
            for (int f = 0; f < fb_pkg::NF; f++) begin
              s_nxt.rep[2 + f] = {1'b0, s_r.pwr[b][f]};
              s_nxt.rep[8 + f] = {1'b0, s_r.glitch[b][f]};
            end
            s_nxt.rep[6] = {4'h0, s_r.mask[b]};
            s_nxt.rep[7] = s_r.tmo[b];
          end else if (sub == fb_pkg::SUB_FAN && idx_ok(s_r.req[1], board_count)
                       && (len == 8'h06 || len == 8'h08 || len == 8'h0c)) begin
            ok = 1'b1;
            // Field ranges checked before anything is stored
            for (int f = 0; f < fb_pkg::NF; f++) begin
              if (s_r.req[2 + f] > fb_pkg::LVL_MAX) begin
                ok = 1'b0;
              end
              if (len == 8'h0c && (s_r.req[8 + f] == 8'h00 || s_r.req[8 + f] > fb_pkg::LVL_MAX)) begin
                ok = 1'b0;
              end
            end
            if (ok) begin
              s_nxt.rep_len = 8'h01;
              for (int f = 0; f < fb_pkg::NF; f++) begin
                s_nxt.pwr[b][f] = s_r.req[2 + f][6:0];
                if (len == 8'h0c) begin
                  s_nxt.glitch[b][f] = s_r.req[8 + f][6:0];
                end
              end
              if (len != 8'h06) begin
                s_nxt.mask[b] = s_r.req[6][3:0];
                s_nxt.tmo[b] = s_r.req[7];
              end
              // Any fan set counts as a refresh
              s_nxt.fs_cnt[b] = 8'h00;
              s_nxt.fs_trip[b] = 1'b0;
            end
          end else if (sub == fb_pkg::SUB_TACH && len == 8'h02
                       && idx_ok(s_r.req[1], board_count)) begin
            ok = 1'b1;
            s_nxt.rep_len = fb_pkg::LEN_TACH;
            for (int f = 0; f < fb_pkg::NF; f++) begin
              s_nxt.rep[2 + 3*f] = cyc_w[b][f];
              s_nxt.rep[3 + 3*f] = tick_w[b][f][7:0];
              s_nxt.rep[4 + 3*f] = tick_w[b][f][15:8];
            end
            s_nxt.tach_en[b] = 1'b1;
            s_nxt.tach_cnt[b] = 9'h000;
            s_nxt.tach_clr[b] = 1'b1;
          end
        end
        s_nxt.err = !ok;
        s_nxt.rep_type = ok ? fb_pkg::REP_TYPE : fb_pkg::ERR_TYPE;
        if (!ok) begin
          s_nxt.rep_len = 8'h00;
          s_nxt.st = fb_pkg::S_IDLE;
        end
        s_nxt.done = (s_nxt.st == fb_pkg::S_IDLE);
      end
      fb_pkg::S_SN: begin
        // Store answers the address set one cycle earlier
        s_nxt.rep[5'(s_r.sn_k) + 5'h02] = sn_byte;
        if (s_r.sn_k == fb_pkg::SN_LAST) begin
          s_nxt.st = fb_pkg::S_IDLE;
          s_nxt.done = 1'b1;
        end else begin
          s_nxt.sn_k = 4'(s_r.sn_k + 4'h1);
          s_nxt.sn_addr = {s_r.sn_addr[8:4], 4'(s_r.sn_k + 4'h1)};
        end
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.st <= fb_pkg::S_IDLE;
      s_r.rsp.awready <= 1'b1;
      s_r.rsp.wready <= 1'b1;
      s_r.rsp.arready <= 1'b1;
      s_r.glitch <= {(fb_pkg::NB * fb_pkg::NF){fb_pkg::GLITCH_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus_rsp = s_r.rsp;
  assign sn_addr = s_r.sn_addr;

  // ==========================================================
  // Board instances
  for (genvar g = 0; g < fb_pkg::NB; g++) begin : g_board
    logic [fb_pkg::NF-1:0] full_on;
    assign full_on = s_r.mask[g] & {fb_pkg::NF{s_r.fs_trip[g]}};
    fan_board u_board (
      .aclk(aclk),
      .aresetn(aresetn),
      .step_tick(s_r.step_tick),
      .phase(s_r.phase),
      .pwr(s_r.pwr[g]),
      .glitch(s_r.glitch[g]),
      .full_on(full_on),
      .tach_en(s_r.tach_en[g]),
      .tach_clr(s_r.tach_clr[g]),
      .tach_in(tach_in[g*fb_pkg::NF +: fb_pkg::NF]),
      .pwm(fan_pwm[g*fb_pkg::NF +: fb_pkg::NF]),
      .cyc(cyc_w[g]),
      .tick(tick_w[g])
    );
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ok_type: assert property ($rose(s_r.done) && !s_r.err |-> s_r.rep_type == fb_pkg::REP_TYPE)
    else $error("success reply type wrong");
  a_err_pkt: assert property ($rose(s_r.done) && s_r.err |-> s_r.rep_type == fb_pkg::ERR_TYPE && s_r.rep_len == 8'h00)
    else $error("error reply malformed");
  a_count_len: assert property ($rose(s_r.done) && !s_r.err && s_r.rep_len == fb_pkg::LEN_INFO |-> s_r.rep[0] == fb_pkg::SUB_INFO)
    else $error("board count reply wrong");
  a_sn_walk: assert property ($rose(s_r.st == fb_pkg::S_SN) |-> ##16 (s_r.st == fb_pkg::S_IDLE && s_r.done && s_r.rep_len == fb_pkg::LEN_SN))
    else $error("serial reply timing wrong");
  a_fan_echo: assert property ($rose(s_r.done) && !s_r.err && s_r.rep_len == 8'h01 |-> s_r.rep[0] == fb_pkg::SUB_FAN)
    else $error("fan set echo wrong");
  a_tach_len: assert property ($rose(s_r.done) && !s_r.err && s_r.rep[0] == fb_pkg::SUB_TACH |-> s_r.rep_len == fb_pkg::LEN_TACH)
    else $error("tach reply length wrong");
  a_fs_trip: assert property (s_r.eighth_tick && s_r.tmo[0] != 8'h00 && 8'(s_r.fs_cnt[0] + 8'h01) == s_r.tmo[0] && s_r.st != fb_pkg::S_EXEC |=> s_r.fs_trip[0])
    else $error("fail-safe did not trip");
  a_tach_stop: assert property (s_r.eighth_tick && s_r.tach_en[0] && s_r.tach_cnt[0] == 9'(fb_pkg::TACH_EIGHTHS - 9'h001) && s_r.st != fb_pkg::S_EXEC |=> !s_r.tach_en[0])
    else $error("tach watchdog did not stop");
  a_phase_rng: assert property (s_r.step_tick |-> s_r.phase < fb_pkg::STEPS ##1 !s_r.step_tick)
    else $error("pwm phase out of range");
  a_bvalid_hold: assert property (s_r.rsp.bvalid && !bus_req.bready |=> s_r.rsp.bvalid)
    else $error("write response dropped");
  // Read data must stand until the master takes it
  a_rvalid_hold: assert property (s_r.rsp.rvalid && !bus_req.rready
      |=> s_r.rsp.rvalid && $stable(s_r.rsp.rdata))
    else $error("read data dropped");
  // A start written while idle always launches; starts while busy are dropped
  a_start_exec: assert property (s_r.st == fb_pkg::S_IDLE && s_r.aw_ok && s_r.w_ok
      && (s_r.awaddr & 8'hfc) == fb_pkg::A_CTRL && s_r.wstrb[0] && s_r.wdata[0]
      |=> s_r.st == fb_pkg::S_EXEC)
    else $error("start not taken");
  // Stored fields stay in range, so a bad field never reaches the fans
  a_level_rng: assert property ({1'b0, s_r.pwr[0][0]} <= fb_pkg::LVL_MAX)
    else $error("stored power out of range");
  a_glitch_rng: assert property (s_r.glitch[0][0] != 7'h00
      && s_r.glitch[0][0] <= fb_pkg::STEPS)
    else $error("stored glitch delay out of range");
  c_sn_read: cover property ($rose(s_r.st == fb_pkg::S_SN) ##16 s_r.done);
  c_err: cover property ($rose(s_r.err));
  c_fs_trip: cover property ($rose(s_r.fs_trip[0]));
  c_tach_off: cover property ($fell(s_r.tach_en[0]));
  c_fan_set: cover property ($rose(s_r.done) && !s_r.err && s_r.rep_len == 8'h01);
endmodule // fan_board_command_group

//--- board_chain.sv
// Purpose: Model of the board chain: serial text store and spinning fans.
// Assumes: Serial store answers at once; a powered fan pulses its tach every 3 cycles.
// Notes: An unpowered fan is a stopped rotor, so its tach line stays low.
`timescale 1ns/1ps
module board_chain (
  // Clock
  input wire logic aclk,
  // Chain
  input wire logic [8:0] sn_addr,
  output logic [7:0] sn_byte,
  input wire logic [127:0] fan_pwm,
  output logic [127:0] tach_in = 128'h0
);
  logic [1:0] ph = 2'h0;
  // Serial byte k of board b reads 0x30 plus b plus k
  assign sn_byte = 8'h30 + {3'h0, sn_addr[8:4]} + {4'h0, sn_addr[3:0]};
  // Powered fans pulse their tach lines
  always @(posedge aclk) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    tach_in <= fan_pwm & {128{ph == 2'h0}};
  end
endmodule // board_chain

//--- fan_board_command_group_bench.sv
// Purpose: Self-checking bench for the fan board command group.
// Assumes: Three boards attached; short time base so periods are 400 cycles.
// Notes: Bus ready lines stay high, so the master never stalls an answer.
`timescale 1ns/1ps
module fan_board_command_group_bench;
  typedef struct packed {
    logic [7:0] t, l;
    logic [31:0] w0, w1, w2;
    logic [7:0] rt, rl;
    logic [31:0] rep0;
  } row_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  fb_pkg::axil_req_s req = '{bready: 1'b1, rready: 1'b1, wstrb: 4'hf, default: '0};
  fb_pkg::axil_rsp_s rsp;
  logic [8:0] sn_addr;
  logic [7:0] sn_byte;
  logic [127:0] tach_in, fan_pwm;
  logic [31:0] s, d, n0, n1;
  logic [1:0] r;
  int err_total = 0;
  int checks_done = 0;
  row_s rows [8] = '{
    '{8'h25, 8'h01, 32'h0, 32'h0, 32'h0, 8'h65, 8'h02, 32'h00000300},
    '{8'h25, 8'h0c, 32'h140a0101, 32'h000f281e, 32'h64320605, 8'h65, 8'h01, 32'h1},
    '{8'h25, 8'h02, 32'h0101, 32'h0, 32'h0, 8'h65, 8'h0c, 32'h140a0101},
    '{8'h25, 8'h02, 32'h0200, 32'h0, 32'h0, 8'h65, 8'h12, 32'h33320200},
    '{8'h25, 8'h02, 32'h0102, 32'h0, 32'h0, 8'h65, 8'h0e, 32'h00000102},
    '{8'h25, 8'h02, 32'h0301, 32'h0, 32'h0, 8'he5, 8'h00, 32'h0},
    '{8'h25, 8'h06, 32'h00650001, 32'h0, 32'h0, 8'he5, 8'h00, 32'h0},
    '{8'h26, 8'h01, 32'h0, 32'h0, 32'h0, 8'he5, 8'h00, 32'h0}
  };
  // 50 MHz clock
  always #10 aclk = ~aclk;
  fan_board_command_group #(.STEP_CYC(4), .EIGHTH_CYC(50)) i_dut (.aclk(aclk),
    .aresetn(aresetn), .bus_req(req), .bus_rsp(rsp), .board_count(6'h03),
    .sn_addr(sn_addr), .sn_byte(sn_byte), .tach_in(tach_in), .fan_pwm(fan_pwm));
  board_chain i_chain (.aclk(aclk), .sn_addr(sn_addr), .sn_byte(sn_byte),
    .fan_pwm(fan_pwm), .tach_in(tach_in));
  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    v = rsp.rdata;
    e = rsp.rresp;
  endtask
  // Load a packet, start it and poll until done
  task automatic run(input logic [7:0] t, l, input logic [31:0] w0, w1, w2);
    logic [1:0] e;
    int k;
    wr(fb_pkg::A_CMD, {16'h0, l, t});
    wr(fb_pkg::A_REQ0, w0);
    wr(8'h14, w1);
    wr(8'h18, w2);
    wr(fb_pkg::A_CTRL, 32'h1);
    k = 0;
    do begin
      rd(fb_pkg::A_STAT, s, e);
      k++;
    end while (s[1:0] !== 2'b10 && k < 200);
  endtask
  task automatic cnt(input int k, input int a, input int b);
    n0 = 0;
    n1 = 0;
    repeat (k) begin
      @(posedge aclk);
      n0 = n0 + fan_pwm[a];
      n1 = n1 + fan_pwm[b];
    end
  endtask
  function automatic logic [31:0] msk(input logic [7:0] l);
    return (l > 8'h3) ? 32'hffffffff : (32'h1 << (8 * l)) - 32'h1;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      run(rows[i].t, rows[i].l, rows[i].w0, rows[i].w1, rows[i].w2);
      chk({16'h0, s[23:8]}, {16'h0, rows[i].rl, rows[i].rt});
      rd(fb_pkg::A_REP0, d, r);
      chk(d & msk(rows[i].rl), rows[i].rep0);
      $display("row %0d done", i);
    end
    // One full period of 100 steps at 4 cycles each
    cnt(400, 4, 5);
    chk(n0, 32'd40);
    chk(n1, 32'd80);
    run(8'h25, 8'h02, 32'h0102, 32'h0, 32'h0);
    rd(fb_pkg::A_REP0, d, r);
    chk({31'h0, d[23:16] != 8'h0}, 32'h1);
    $display("duty and tach done");
    // Fail-safe on fan 0 of board 0, timeout of two eighths
    run(8'h25, 8'h08, 32'h1, 32'h02010000, 32'h0);
    repeat (300) @(posedge aclk);
    cnt(50, 0, 1);
    chk(n0, 32'd50);
    chk(n1, 32'd0);
    run(8'h25, 8'h06, 32'h1, 32'h0, 32'h0);
    repeat (3) @(posedge aclk);
    chk({31'h0, fan_pwm[0]}, 32'h0);
    $display("fail-safe done");
    // Second reset restores default glitch delays
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(fan_pwm[31:0], 32'h0);
    run(8'h25, 8'h02, 32'h0101, 32'h0, 32'h0);
    rd(8'h28, d, r);
    chk(d, 32'h01010101);
    rd(8'h40, d, r);
    chk({30'h0, r}, {30'h0, fb_pkg::RESP_SLVERR});
    wr(8'h40, 32'h0);
    chk({30'h0, r}, {30'h0, fb_pkg::RESP_SLVERR});
    $display("reset done");
    stop_test();
  end
  // Hang guard, far beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    stop_test();
  end
endmodule // fan_board_command_group_bench
